// >>> verilog/cbl_map.svh
`ifndef CBL_MAP_SVH
`define CBL_MAP_SVH

// Register offsets on the host bus
`define CBL_OFS_DATA      8'hc5
`define CBL_OFS_TSEL      8'hc6
`define CBL_OFS_BOFS      8'hc7
`define CBL_OFS_TALLY     8'hc8
`define CBL_OFS_LOOP      8'hc9
`define CBL_OFS_REFRESH   8'hca

// Field layout and reset values
`define CBL_TSEL_MSB      5
`define CBL_ZERO_BYTE     8'h00
`define CBL_LOOP_RST      8'h01
`define CBL_LOOP_ONCE     8'h01
`define CBL_LOOP_FOREVER  8'h00
`define CBL_REFRESH_RST   8'h00
`define CBL_TALLY_MAX     8'hff
`define CBL_INVALID_DATA  8'hff

// Channel buffer geometry
`define CBL_BUF_BYTES     14'd4352
`define CBL_BUF_AW        13

// Refresh step timing
`define CBL_STEP_NS       100000
`define CBL_CLK_NS        5

`endif

// >>> verilog/cbl_pkg.sv
package cbl_pkg;

   // Sequence loop controller states
   typedef enum logic [1:0]
   {
      CBL_IDLE,
      CBL_RUN,
      CBL_WAIT
   } cbl_loop_state_t;

endpackage

// >>> verilog/cbl_buffer_mem.sv
`include "cbl_map.svh"

// Two-port channel byte buffer, registered read data on both ports
module cbl_buffer_mem
(
   // Clock
   input  wire logic                     clk_sys,
   // Host side port
   input  wire logic                     a_we,
   input  wire logic [`CBL_BUF_AW-1:0]   a_addr,
   input  wire logic [7:0]               a_wdata,
   output logic      [7:0]               a_rdata,
   // Serial engine port
   input  wire logic                     b_we,
   input  wire logic [`CBL_BUF_AW-1:0]   b_addr,
   input  wire logic [7:0]               b_wdata,
   output logic      [7:0]               b_rdata
);

   // Storage array; no reset so it maps onto block memory
   logic [7:0] store [0:4351];

   // Port A write and read-before-write data
   always_ff @(posedge clk_sys)
   begin
      if (a_we)
      begin
         store[a_addr] <= a_wdata;
      end
      a_rdata <= store[a_addr];
   end

   // Port B write and read; bytes kept bit for bit, no inversion
   always_ff @(posedge clk_sys)
   begin
      if (b_we)
      begin
         store[b_addr] <= b_wdata;
      end
      b_rdata <= store[b_addr];
   end

endmodule

// >>> verilog/cbl_channel_regs.sv
`include "cbl_map.svh"

// One channel of buffer pointer, byte tally and sequence loop logic
module cbl_channel_regs
#(
   // Cycles per 100us refresh step; shorten for simulation
   parameter int STEP_CYCLES = `CBL_STEP_NS / `CBL_CLK_NS
)
(
   // Clock and reset
   input  wire logic                     clk_sys,
   input  wire logic                     reset,
   // Host parallel register port
   input  wire logic [7:0]               host_addr,
   input  wire logic                     host_wr,
   input  wire logic                     host_rd,
   input  wire logic [7:0]               host_wdata,
   output logic      [7:0]               host_rdata,
   output logic                          host_rdata_valid,
   // Transaction table lookup
   output logic      [5:0]               transaction_index,
   input  wire logic [12:0]              sel_base_addr,
   input  wire logic                     sel_base_valid,
   // Channel controls
   input  wire logic                     pointer_rewind_bit,
   input  wire logic                     trigger_enable,
   input  wire logic                     ext_trigger,
   input  wire logic                     seq_go,
   input  wire logic                     buffer_error_clear,
   input  wire logic                     frame_error_clear,
   // Serial engine side
   input  wire logic [12:0]              eng_addr,
   input  wire logic                     eng_we,
   input  wire logic [7:0]               eng_wdata,
   output logic      [7:0]               eng_rdata,
   input  wire logic                     eng_byte_done,
   input  wire logic                     eng_byte_is_read,
   input  wire logic                     eng_byte_acked,
   input  wire logic                     eng_seq_done,
   // Sequencing and status
   output logic                          seq_launch,
   output logic                          seq_stop_req,
   output logic                          loop_done,
   output logic                          channel_idle,
   output logic                          buffer_error_flag,
   output logic                          frame_error_flag,
   output logic                          frame_error_irq
);

   // Host registers
   logic [7:0]                 byte_offset_select;     // Byte index in transaction
   logic [7:0]                 transferred_byte_tally; // Live byte count
   logic [7:0]                 loop_repeat_setting;    // Programmed pass count
   logic [7:0]                 refresh_period_setting; // Start spacing in steps

   // Data port pointer
   logic [13:0]                data_ptr;               // Wide enough to exceed buffer
   logic                       ptr_ok;                 // Selected entry was initialised
   logic                       ptr_reload;             // Reload from select registers

   // Read pipeline
   logic                       rd_stage;               // Read in flight
   logic                       rd_is_data;             // In-flight read is data port
   logic                       rd_invalid;             // Data read outside buffer
   logic [7:0]                 rd_hold;                // Register read value
   logic [7:0]                 mem_a_rdata;            // Buffer read data

   // Loop controller
   cbl_pkg::cbl_loop_state_t   loop_state;
   logic [7:0]                 loop_cap;               // Repeat setting at go
   logic [7:0]                 passes_left;            // Passes still to run
   logic                       late_pass;              // Period expired mid pass
   logic [15:0]                step_cnt;               // Cycles within a step
   logic [7:0]                 period_cnt;             // Steps since last start
   logic                       step_tick;
   logic                       period_elapsed;
   logic                       timer_on;
   logic                       last_pass;

   // Decoded host strobes
   logic                       wr_data;
   logic                       rd_data;
   logic                       data_access;
   logic                       out_of_range;
   logic                       mem_we;

   // Address decode
   always_comb
   begin
      wr_data = 1'b0;
      rd_data = 1'b0;
      if (host_addr == `CBL_OFS_DATA)
      begin
         wr_data = host_wr && channel_idle;
         rd_data = host_rd;
      end
   end

   // Pointer range check; an uninitialised entry or a sum past the end both count
   assign out_of_range  = !ptr_ok || (data_ptr >= `CBL_BUF_BYTES);
   assign data_access   = wr_data || rd_data;
   assign mem_we        = wr_data && !out_of_range;

   // Timer is only live while looping on its own spacing
   assign timer_on = (refresh_period_setting != `CBL_REFRESH_RST)
                     && (loop_repeat_setting != `CBL_LOOP_ONCE)
                     && !trigger_enable;
   assign step_tick      = (step_cnt == 16'(STEP_CYCLES - 1));
   assign period_elapsed = step_tick && ((period_cnt + 8'h01) == refresh_period_setting);

   // Last pass: once-only, or counted passes used up; zero never ends
   assign last_pass = (loop_cap == `CBL_LOOP_ONCE)
                      || ((loop_cap != `CBL_LOOP_FOREVER)
                          && (passes_left == `CBL_LOOP_ONCE));

   // Transaction select; host write only
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         transaction_index <= 6'h00;
      end
      else if (host_wr && host_addr == `CBL_OFS_TSEL)
      begin
         transaction_index <= host_wdata[`CBL_TSEL_MSB:0];
      end
   end

   // Byte offset; a new selection forces it back to zero
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         byte_offset_select <= `CBL_ZERO_BYTE;
      end
      else if (host_wr && host_addr == `CBL_OFS_TSEL)
      begin
         byte_offset_select <= `CBL_ZERO_BYTE;
      end
      else if (host_wr && host_addr == `CBL_OFS_BOFS)
      begin
         byte_offset_select <= host_wdata;
      end
   end

   // Reload request; the table base follows the new index one cycle later
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         ptr_reload <= 1'b1;
      end
      else
      begin
         ptr_reload <= (host_wr && (host_addr == `CBL_OFS_TSEL
                                    || host_addr == `CBL_OFS_BOFS))
                       || pointer_rewind_bit;
      end
   end

   // Data pointer: load base plus offset, then step on each data access until bit 13 is set
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         data_ptr <= 14'h0000;
         ptr_ok   <= 1'b0;
      end
      else if (ptr_reload)
      begin
         data_ptr <= {1'b0, sel_base_addr} + {6'h00, byte_offset_select};
         ptr_ok   <= sel_base_valid;
      end
      else if (data_access && !data_ptr[13])
      begin
         // No stop at the transaction length; walks into the next region
         data_ptr <= data_ptr + 14'h0001;
      end
   end

   // Buffer error is sticky; a fresh error beats the host clear
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         buffer_error_flag <= 1'b0;
      end
      else if ((data_access || (host_wr && host_addr == `CBL_OFS_DATA)) && out_of_range)
      begin
         buffer_error_flag <= 1'b1;
      end
      else if (buffer_error_clear)
      begin
         buffer_error_flag <= 1'b0;
      end
   end

   // Loop repeat and refresh settings
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         loop_repeat_setting    <= `CBL_LOOP_RST;
         refresh_period_setting <= `CBL_REFRESH_RST;
      end
      else if (host_wr && host_addr == `CBL_OFS_LOOP)
      begin
         loop_repeat_setting <= host_wdata;
      end
      else if (host_wr && host_addr == `CBL_OFS_REFRESH)
      begin
         refresh_period_setting <= host_wdata;
      end
   end

   // Byte tally; cleared at launch, counts accepted bytes, sticks at the top
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         transferred_byte_tally <= `CBL_ZERO_BYTE;
      end
      else if (seq_launch)
      begin
         transferred_byte_tally <= `CBL_ZERO_BYTE;
      end
      else if (eng_byte_done && (eng_byte_is_read || eng_byte_acked)
               && transferred_byte_tally != `CBL_TALLY_MAX)
      begin
         transferred_byte_tally <= transferred_byte_tally + 8'h01;
      end
   end

   // Read stage one: latch what to return while the buffer fetches
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         rd_stage   <= 1'b0;
         rd_is_data <= 1'b0;
         rd_invalid <= 1'b0;
         rd_hold    <= `CBL_ZERO_BYTE;
      end
      else
      begin
         rd_stage   <= host_rd;
         rd_is_data <= rd_data;
         rd_invalid <= out_of_range;
         if (host_addr == `CBL_OFS_TSEL)
         begin
            rd_hold <= {2'b00, transaction_index};
         end
         else if (host_addr == `CBL_OFS_BOFS)
         begin
            rd_hold <= byte_offset_select;
         end
         else if (host_addr == `CBL_OFS_TALLY)
         begin
            rd_hold <= transferred_byte_tally;
         end
         else if (host_addr == `CBL_OFS_LOOP)
         begin
            rd_hold <= loop_repeat_setting;
         end
         else if (host_addr == `CBL_OFS_REFRESH)
         begin
            rd_hold <= refresh_period_setting;
         end
         else
         begin
            // Unmapped offsets read as zero
            rd_hold <= `CBL_ZERO_BYTE;
         end
      end
   end

   // Read stage two: answer to the host
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         host_rdata       <= `CBL_ZERO_BYTE;
         host_rdata_valid <= 1'b0;
      end
      else
      begin
         host_rdata_valid <= rd_stage;
         if (rd_stage && rd_is_data)
         begin
            host_rdata <= rd_invalid ? `CBL_INVALID_DATA : mem_a_rdata;
         end
         else if (rd_stage)
         begin
            host_rdata <= rd_hold;
         end
      end
   end

   // Refresh timer; restarts at every launch so periods run start to start
   always_ff @(posedge clk_sys)
   begin
      if (reset || loop_state == cbl_pkg::CBL_IDLE)
      begin
         step_cnt   <= 16'h0000;
         period_cnt <= 8'h00;
      end
      else if (seq_launch)
      begin
         // Launch edge is the first cycle of the period
         step_cnt   <= 16'h0001;
         period_cnt <= 8'h00;
      end
      else if (step_tick)
      begin
         step_cnt   <= 16'h0000;
         period_cnt <= period_elapsed ? 8'h00 : period_cnt + 8'h01;
      end
      else
      begin
         step_cnt <= step_cnt + 16'h0001;
      end
   end

   // Frame error: period ran out while a pass was still on the bus
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         frame_error_flag <= 1'b0;
         frame_error_irq  <= 1'b0;
      end
      else
      begin
         frame_error_irq <= 1'b0;
         if (loop_state == cbl_pkg::CBL_RUN && timer_on
             && period_elapsed && !eng_seq_done)
         begin
            frame_error_flag <= 1'b1;
            frame_error_irq  <= 1'b1;
         end
         else if (frame_error_clear)
         begin
            frame_error_flag <= 1'b0;
         end
      end
   end

   // Sequence loop controller
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         loop_state   <= cbl_pkg::CBL_IDLE;
         loop_cap     <= `CBL_LOOP_RST;
         passes_left  <= `CBL_LOOP_RST;
         late_pass    <= 1'b0;
         seq_launch   <= 1'b0;
         seq_stop_req <= 1'b0;
         loop_done    <= 1'b0;
         channel_idle <= 1'b1;
      end
      else
      begin
         seq_launch <= 1'b0;
         loop_done  <= 1'b0;
         case (loop_state)
            cbl_pkg::CBL_IDLE:
            begin
               if (seq_go)
               begin
                  loop_cap     <= loop_repeat_setting;
                  passes_left  <= loop_repeat_setting;
                  late_pass    <= 1'b0;
                  seq_launch   <= 1'b1;
                  seq_stop_req <= 1'b1;
                  channel_idle <= 1'b0;
                  loop_state   <= cbl_pkg::CBL_RUN;
               end
            end
            cbl_pkg::CBL_RUN:
            begin
               if (timer_on && period_elapsed && !eng_seq_done)
               begin
                  // Overrun: next pass starts as soon as this one ends
                  late_pass <= 1'b1;
               end
               if (eng_seq_done)
               begin
                  if (last_pass)
                  begin
                     loop_done    <= 1'b1;
                     seq_stop_req <= 1'b0;
                     channel_idle <= 1'b1;
                     loop_state   <= cbl_pkg::CBL_IDLE;
                  end
                  else
                  begin
                     if (loop_cap != `CBL_LOOP_FOREVER)
                     begin
                        passes_left <= passes_left - 8'h01;
                     end
                     if (trigger_enable || (timer_on && !late_pass))
                     begin
                        loop_state <= cbl_pkg::CBL_WAIT;
                     end
                     else
                     begin
                        seq_launch <= 1'b1;
                        late_pass  <= 1'b0;
                     end
                  end
               end
            end
            cbl_pkg::CBL_WAIT:
            begin
               if (trigger_enable ? ext_trigger : (!timer_on || period_elapsed))
               begin
                  seq_launch <= 1'b1;
                  late_pass  <= 1'b0;
                  loop_state <= cbl_pkg::CBL_RUN;
               end
            end
            default:
            begin
               loop_state <= cbl_pkg::CBL_IDLE;
            end
         endcase
      end
   end

   // Channel buffer; host bytes pass unaltered to the serial engine
   cbl_buffer_mem u_buffer
   (
      .clk_sys (clk_sys),
      .a_we    (mem_we),
      .a_addr  (data_ptr[12:0]),
      .a_wdata (host_wdata),
      .a_rdata (mem_a_rdata),
      .b_we    (eng_we),
      .b_addr  (eng_addr),
      .b_wdata (eng_wdata),
      .b_rdata (eng_rdata)
   );

endmodule

// >>> verification/cbl_far_model.sv
// Far side of one channel: transaction table lookup and a serial engine stand-in
module cbl_far_model
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset,
   // Transaction table lookup
   input  wire logic [5:0]  transaction_index,
   output logic      [12:0] sel_base_addr,
   output logic             sel_base_valid,
   // Serial engine
   input  wire logic        seq_launch,
   input  wire logic [15:0] nbytes,
   input  wire logic        rd_mode,
   output logic      [12:0] eng_addr,
   output logic             eng_we,
   output logic      [7:0]  eng_wdata,
   output logic             eng_byte_done,
   output logic             eng_byte_is_read,
   output logic             eng_byte_acked,
   output logic             eng_seq_done
);
   timeunit 1ns;
   timeprecision 1ps;
   int pos = -1; // Next byte of the pass, -1 while the bus is quiet

   // Entries of 72 bytes; only the first 60 are set up, later ones run off the buffer
   assign sel_base_addr  = 13'(transaction_index * 72);
   assign sel_base_valid = transaction_index < 6'h3c;
   // Received bytes land in the buffer; only odd bytes of a write pass are acked
   assign eng_we           = eng_byte_done & rd_mode;
   assign eng_byte_is_read = rd_mode;
   assign eng_byte_acked   = eng_addr[0];

   // One byte a cycle, then the STOP; data flips when idle so no stale value lingers
   always @(posedge clk_sys)
   begin
      eng_byte_done <= 1'h0;
      eng_seq_done  <= 1'h0;
      eng_wdata     <= ~eng_wdata;
      if (reset)
      begin
         pos       <= -1;
         eng_addr  <= 13'h0000;
         eng_wdata <= 8'h00;
      end
      else if (seq_launch)
         pos <= 0;
      else if (pos >= 0 && pos < nbytes)
      begin
         eng_byte_done <= 1'h1;
         eng_addr      <= 13'(pos);
         eng_wdata     <= 8'(pos) ^ 8'h5a;
         pos           <= pos + 1;
      end
      else if (pos >= 0)
      begin
         eng_seq_done <= 1'h1;
         pos          <= -1;
      end
   end
endmodule

// >>> verification/cbl_channel_props.sv
// Port level checks of one channel
module cbl_channel_props
(
   // Clock and reset
   input wire logic       clk_sys,
   input wire logic       reset,
   // Host port
   input wire logic [7:0] host_addr,
   input wire logic       host_wr,
   input wire logic       host_rd,
   input wire logic [7:0] host_wdata,
   input wire logic [7:0] host_rdata,
   input wire logic       host_rdata_valid,
   // Table and controls
   input wire logic [5:0] transaction_index,
   input wire logic       sel_base_valid,
   input wire logic       buffer_error_clear,
   input wire logic       seq_go,
   input wire logic       eng_seq_done,
   // Status
   input wire logic       seq_launch,
   input wire logic       seq_stop_req,
   input wire logic       loop_done,
   input wire logic       channel_idle,
   input wire logic       buffer_error_flag,
   input wire logic       frame_error_flag,
   input wire logic       frame_error_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   chk_rd_answer: assert property (host_rd |-> ##2 host_rdata_valid)
      else $error("read answer missing");
   chk_tsel_load: assert property (host_wr && host_addr == 8'hc6
      |=> transaction_index == 6'($past(host_wdata))) else $error("select not loaded");
   chk_bad_read: assert property (host_rd && host_addr == 8'hc5 && !sel_base_valid
      |-> ##1 buffer_error_flag ##1 host_rdata == 8'hff) else $error("bad read passed");
   chk_be_hold: assert property (buffer_error_flag && !buffer_error_clear
      |=> buffer_error_flag) else $error("buffer error dropped");
   chk_go_launch: assert property (seq_go && channel_idle |=> seq_launch)
      else $error("no launch after go");
   chk_done_cause: assert property (loop_done |-> $past(eng_seq_done))
      else $error("loop end without pass end");
   chk_done_idle: assert property (loop_done |-> channel_idle && !seq_stop_req)
      else $error("not idle at loop end");
   chk_stop_each: assert property (seq_launch |-> seq_stop_req && !channel_idle)
      else $error("launch without stop request");
   chk_fe_irq: assert property ($rose(frame_error_flag) |-> frame_error_irq)
      else $error("frame error without irq");
   chk_irq_pulse: assert property (frame_error_irq |=> !frame_error_irq)
      else $error("irq longer than a cycle");
endmodule

// >>> verification/cbl_channel_regs_tb_top.sv
module cbl_channel_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // Bench driven inputs
   logic        clk_sys = 1'h0, reset = 1'h1, host_wr = 1'h0, host_rd = 1'h0;
   logic [7:0]  host_addr = 8'h00, host_wdata = 8'h00;
   logic        pointer_rewind_bit = 1'h0, trigger_enable = 1'h0, ext_trigger = 1'h0;
   logic        seq_go = 1'h0, buffer_error_clear = 1'h0, frame_error_clear = 1'h0;
   logic        rd_mode = 1'h1;
   logic [15:0] nbytes = 16'h0001;
   // Design outputs and far side wires
   logic [7:0]  host_rdata, eng_wdata, eng_rdata;
   logic [12:0] sel_base_addr, eng_addr;
   logic [5:0]  transaction_index;
   logic        host_rdata_valid, sel_base_valid, eng_we, eng_byte_done, eng_byte_is_read;
   logic        eng_byte_acked, eng_seq_done, seq_launch, seq_stop_req, loop_done;
   logic        channel_idle, buffer_error_flag, frame_error_flag, frame_error_irq;
   // Bookkeeping
   int          fail_count = 0, num_checks = 0;
   int          cyc = 0, lastc = 0, gap = 0, launches = 0, dones = 0;

   // Step shortened to 4 cycles so refresh periods stay short
   cbl_channel_regs #(.STEP_CYCLES(4)) i_dut
   (
      .clk_sys, .reset, .host_addr, .host_wr, .host_rd, .host_wdata, .host_rdata,
      .host_rdata_valid, .transaction_index, .sel_base_addr, .sel_base_valid,
      .pointer_rewind_bit, .trigger_enable, .ext_trigger, .seq_go, .buffer_error_clear,
      .frame_error_clear, .eng_addr, .eng_we, .eng_wdata, .eng_rdata, .eng_byte_done,
      .eng_byte_is_read, .eng_byte_acked, .eng_seq_done, .seq_launch, .seq_stop_req,
      .loop_done, .channel_idle, .buffer_error_flag, .frame_error_flag, .frame_error_irq
   );
   cbl_far_model i_far
   (
      .clk_sys, .reset, .transaction_index, .sel_base_addr, .sel_base_valid, .seq_launch,
      .nbytes, .rd_mode, .eng_addr, .eng_we, .eng_wdata, .eng_byte_done, .eng_byte_is_read,
      .eng_byte_acked, .eng_seq_done
   );

   always #2.5 clk_sys = ~clk_sys;

   // Launch count, launch spacing in cycles and loop ends
   always @(posedge clk_sys)
   begin
      cyc++;
      if (seq_launch)
      begin
         gap = cyc - lastc;
         lastc = cyc;
         launches++;
      end
      dones += loop_done;
   end

   task automatic check(logic [7:0] seen, logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Tally seen after one pass: all bytes when reading, odd acked bytes when writing
   function automatic logic [7:0] exp_tally(int n, logic r);
      int c;
      c = r ? n : n / 2;
      return (c > 255) ? 8'hff : 8'(c);
   endfunction

   // Host write: one strobe cycle, a gap cycle keeps strobes apart
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clk_sys);
      #1;
      host_addr  = a;
      host_wdata = d;
      host_wr    = 1'h1;
      @(posedge clk_sys);
      #1;
      host_wr = 1'h0;
   endtask

   // Host read; answer looked at two cycles after the strobe edge
   task automatic rc(logic [7:0] a, logic [7:0] exp);
      @(posedge clk_sys);
      #1;
      host_addr = a;
      host_rd   = 1'h1;
      @(posedge clk_sys);
      #1;
      host_rd = 1'h0;
      @(posedge clk_sys);
      #1;
      check(host_rdata_valid, 1'h1);
      check(host_rdata, exp);
   endtask

   task automatic pulse(ref logic s);
      @(posedge clk_sys);
      #1;
      s = 1'h1;
      @(posedge clk_sys);
      #1;
      s = 1'h0;
   endtask

   // Offset is written only when nonzero, so a zero relies on the select clearing it
   task automatic sel(logic [7:0] t, logic [7:0] o);
      wr(8'hc6, t);
      if (o != 8'h00)
         wr(8'hc7, o);
   endtask

   // One loop run; a data write while busy must be dropped
   task automatic run(logic [7:0] rep, rate, input int exp_n, eg);
      wr(8'hc9, rep);
      wr(8'hca, rate);
      {launches, dones} = 0;
      pulse(seq_go);
      wr(8'hc5, 8'h00);
      for (int i = 0; i < 3000 && dones == 0; i++)
         @(posedge clk_sys);
      #1;
      check(8'(launches), 8'(exp_n));
      if (eg != 0)
         check(8'(gap), 8'(eg));
      rc(8'hc8, exp_tally(nbytes, rd_mode));
   endtask

   initial
   begin
      logic [7:0] v;
      logic [7:0] q[4];
      void'($urandom(32'hba4dad07));
      repeat (6) @(posedge clk_sys);
      #1;
      reset = 1'h0;
      rc(8'hc9, 8'h01);
      rc(8'hca, 8'h00);
      rc(8'hc8, 8'h00);
      v = 8'($urandom);
      wr(8'hc9, v);
      rc(8'hc9, v);
      wr(8'hc8, v | 8'h01);
      rc(8'hc8, 8'h00);
      // Fill across the end of entry 1 into entry 2
      sel(8'h01, 8'h46);
      foreach (q[i])
      begin
         q[i] = 8'($urandom);
         wr(8'hc5, q[i]);
      end
      sel(8'h02, 8'h00);
      rc(8'hc5, q[2]);
      rc(8'hc5, q[3]);
      pulse(pointer_rewind_bit);
      rc(8'hc5, q[2]);
      sel(8'h01, 8'h47);
      rc(8'hc5, q[1]);
      // Uninitialised entry, then an offset past the buffer end
      sel(8'h3e, 8'h00);
      wr(8'hc5, 8'h00);
      rc(8'hc5, 8'hff);
      check(buffer_error_flag, 1'h1);
      pulse(buffer_error_clear);
      check(buffer_error_flag, 1'h0);
      sel(8'h3b, 8'hff);
      rc(8'hc5, 8'hff);
      // Single pass with refresh set; busy write must not land
      sel(8'h05, 8'h00);
      wr(8'hc5, 8'ha5);
      sel(8'h05, 8'h00);
      nbytes = 16'($urandom_range(20, 8));
      run(8'h01, 8'h02, 1, 0);
      check(frame_error_flag, 1'h0);
      sel(8'h05, 8'h00);
      rc(8'hc5, 8'ha5);
      sel(8'h00, 8'h00);
      rc(8'hc5, 8'h5a);
      rc(8'hc5, 8'h5b);
      check(eng_rdata, 8'(nbytes - 1) ^ 8'h5a);
      // Write passes: back to back, timed, then overrun
      rd_mode = 1'h0;
      nbytes = 16'($urandom_range(20, 1));
      run(8'h03, 8'h00, 3, 0);
      nbytes = 16'h0003;
      run(8'h03, 8'h02, 3, 8);
      nbytes = 16'h000a;
      run(8'h02, 8'h01, 2, 0);
      check(frame_error_flag, 1'h1);
      pulse(frame_error_clear);
      check(frame_error_flag, 1'h0);
      // Tally saturates on a long read pass
      rd_mode = 1'h1;
      nbytes = 16'd300;
      run(8'h01, 8'h00, 1, 0);
      // Trigger mode: second pass waits for the strobe
      nbytes = 16'h0002;
      trigger_enable = 1'h1;
      {launches, dones} = 0;
      wr(8'hc9, 8'h02);
      pulse(seq_go);
      repeat (40) @(posedge clk_sys);
      #1;
      check(8'(launches), 8'h01);
      pulse(ext_trigger);
      repeat (40) @(posedge clk_sys);
      #1;
      check(8'(launches + dones), 8'h03);
      trigger_enable = 1'h0;
      // Endless loop, ended only by reset
      wr(8'hc9, 8'h00);
      {launches, dones} = 0;
      pulse(seq_go);
      repeat (60) @(posedge clk_sys);
      #1;
      check(8'(launches > 8), 8'h01);
      check(dones[7:0], 8'h00);
      reset = 1'h1;
      repeat (6) @(posedge clk_sys);
      #1;
      reset = 1'h0;
      check(channel_idle, 1'h1);
      rc(8'hc9, 8'h01);
      end_of_test();
   end

   // Hang guard, far beyond the several hundred cycles the run needs
   initial
   begin
      #100us;
      fail_count++;
      end_of_test();
   end
endmodule

bind cbl_channel_regs cbl_channel_props i_chk
(
   .clk_sys, .reset, .host_addr, .host_wr, .host_rd, .host_wdata, .host_rdata,
   .host_rdata_valid, .transaction_index, .sel_base_valid, .buffer_error_clear, .seq_go,
   .eng_seq_done, .seq_launch, .seq_stop_req, .loop_done, .channel_idle,
   .buffer_error_flag, .frame_error_flag, .frame_error_irq
);
